//--- rtl/csf_flag_unit.sv
// Purpose: Sticky flags and rate holding for one counter
// Assumes: Events and clears are single-cycle pulses on mclk
// Notes:   A set in the same cycle as its clear wins
`timescale 1ns/1ns
module csf_flag_unit
   import csf_pkg::*;
(
   // Clock and reset
   input  wire logic          mclk,
   input  wire logic          rstn,
   // Events and clears
   input  wire csf_evt_s      evt,
   input  wire csf_clr_s      clr,
   input  wire logic          pw_set,
   input  wire logic [CW-1:0] rate_in,
   // Flags and rate
   output logic [3:0]         sticky_r,   // {pw, idx, udf, ovf}
   output logic               rv_r,
   output logic [CW-1:0]      rate_r
);

   logic [3:0]    set_v;       // Set requests
   logic [3:0]    clr_v;       // Clear requests
   logic [3:0]    sticky_nxt;  // Next sticky state
   logic          hit_r;       // Over/underflow seen this period
   logic          bad;         // Period spoiled by over/underflow
   logic          rv_nxt;
   logic [CW-1:0] rate_nxt;

   assign set_v = {pw_set, evt.idx, evt.udf, evt.ovf};
   assign clr_v = {clr.pw, clr.idx, clr.udf, clr.ovf};
   // Set has priority so no event is lost in a clearing cycle
   assign sticky_nxt = set_v | (sticky_r & ~clr_v); // RULE_09 RULE_10 RULE_15
   assign bad        = hit_r | evt.ovf | evt.udf;   // RULE_07
   // Drop validity at once on a wrap; decide again at the period end
   assign rv_nxt   = evt.tick ? ~bad : (rv_r & ~(evt.ovf | evt.udf)); // RULE_05 RULE_07
   // Rate only moves when the new sample is good; else last good value
   assign rate_nxt = (evt.tick && !bad) ? rate_in : rate_r; // RULE_06

   // Flag and rate state
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         sticky_r <= 4'h0;            // RULE_12
         hit_r    <= 1'b0;
         rv_r     <= 1'b0;
         rate_r   <= '0;
      end else begin
         sticky_r <= sticky_nxt;
         hit_r    <= evt.tick ? 1'b0 : bad;
         rv_r     <= rv_nxt;
         rate_r   <= rate_nxt;
      end
   end

   // Checks
   AST_STICKY_HOLD: assert property (@(posedge mclk) disable iff (!rstn) // RULE_10
      (sticky_r[0] && !clr.ovf) |=> sticky_r[0])
      else $error("overflow flag fell without a clear");
   AST_CLEAR_EDGE: assert property (@(posedge mclk) disable iff (!rstn) // RULE_15
      (clr.udf && !evt.udf) |=> !sticky_r[1])
      else $error("underflow flag not cleared by clear edge");
   AST_PW_CLEAR: assert property (@(posedge mclk) disable iff (!rstn) // RULE_09
      (clr.pw && !pw_set) |=> !sticky_r[3])
      else $error("preset warning not cleared by clear edge");
   AST_RATE_FROZEN: assert property (@(posedge mclk) disable iff (!rstn) // RULE_06
      (!rv_r && !evt.tick) |=> $stable(rate_r))
      else $error("rate moved while not valid");
   AST_RV_DROP: assert property (@(posedge mclk) disable iff (!rstn) // RULE_07
      (evt.ovf || evt.udf) |=> !rv_r ##1 (!rv_r || $past(evt.tick)))
      else $error("rate valid not dropped after wrap");
   AST_RATE_LOAD: assert property (@(posedge mclk) disable iff (!rstn) // RULE_05
      (evt.tick && !bad) |=> (rv_r && rate_r == $past(rate_in)))
      else $error("good sample not loaded");
   COV_RV_BACK: cover property (@(posedge mclk) disable iff (!rstn)
      !rv_r ##1 rv_r);

endmodule

//--- rtl/csf_pkg.sv
// Purpose: Shared constants and carriers for the counter status and error flag block
// Assumes: Four counters, 32-bit counts and rates, 32-bit register port with byte offsets
// Notes:   Offsets are byte addresses; counter n of a bank sits at bank base + 4*n
package csf_pkg;

   // Sizes
   localparam int NCTR = 4;                        // Counters handled
   localparam int CW   = 32;                       // Count and rate width
   localparam int AW   = 8;                        // Register address width
   localparam int CTLW = 8;                        // Control bits per counter

   // Register offsets, single words
   localparam logic [7:0] A_OUT_CTRL   = 8'h00;    // Staged control bits
   localparam logic [7:0] A_OUT_COMMIT = 8'h04;    // Submit output array
   localparam logic [7:0] A_CFG_QTY    = 8'h08;    // Staged counter_quantity
   localparam logic [7:0] A_CFG_COMMIT = 8'h0C;    // Submit configuration array
   localparam logic [7:0] A_ERR        = 8'h10;    // Module error summary

   // Register banks, one word per counter, selected by address bits 7:4
   localparam logic [3:0] B_DIRECT = 4'h2;         // high_limit_or_direct_value
   localparam logic [3:0] B_MAX    = 4'h3;         // maximum_count
   localparam logic [3:0] B_MIN    = 4'h4;         // minimum_count
   localparam logic [3:0] B_PRESET = 4'h5;         // preset_value
   localparam logic [3:0] B_STAT   = 4'h6;         // Status flags, read only
   localparam logic [3:0] B_RATE   = 4'h7;         // reported_rate, read only

   // Control bit positions inside a counter's control byte
   localparam int CB_CLR_OVF = 0;                  // clear_overflow
   localparam int CB_CLR_UDF = 1;                  // clear_underflow
   localparam int CB_CLR_IDX = 2;                  // clear of index_rise_seen
   localparam int CB_CLR_PW  = 3;                  // clear_preset_warning
   localparam int CB_RUN     = 4;                  // Counter run enable

   // Error summary bit positions
   localparam int EB_HW  = 0;                      // Hardware fault
   localparam int EB_CFG = 1;                      // Error indicator, faults and configuration errors
   localparam int EB_REJ = 2;                      // Last output array rejected

   // Values after reset
   localparam logic [31:0] RST_MAX    = 32'h7FFF_FFFF;
   localparam logic [31:0] RST_MIN    = 32'h8000_0000;
   localparam logic [31:0] RST_PRESET = 32'h0000_0000;
   localparam logic [31:0] RST_DIRECT = 32'h0000_0000;
   localparam logic [31:0] RST_CTRL   = 32'h0000_0000;
   localparam logic [2:0]  RST_QTY    = 3'h3;

   // Which counters own an index flag and an invalid-counter flag
   localparam logic [3:0] IDX_PRESENT = 4'h3;
   localparam logic [3:0] IC_PRESENT  = 4'hE;

   // Status word of one counter, bit 0 first from the right
   typedef struct packed {
      logic pw;   // preset_warning
      logic rv;   // rate_valid
      logic ic;   // invalid_counter
      logic direct_write_invalid;  // direct_write_invalid
      logic idx;  // index_rise_seen
      logic udf;  // count_underflow
      logic ovf;  // count_overflow
   } csf_stat_s;

   // Events from the counting engine, one-cycle pulses
   typedef struct packed {
      logic ovf;   // Overflow or roll-over
      logic udf;   // Underflow or roll-under
      logic idx;   // Qualified index rising edge
      logic tick;  // End of a rate_update_period
   } csf_evt_s;

   // Clear pulses, one cycle, from accepted control rising edges
   typedef struct packed {
      logic pw;
      logic idx;
      logic udf;
      logic ovf;
   } csf_clr_s;

endpackage

//--- rtl/csf_top.sv
// Purpose: Status and error flags of a four-counter pulse counting module
// Assumes: Counting engine supplies events, counts and raw rates on mclk
// Notes:   Output and configuration arrays are staged, then submitted whole
`timescale 1ns/1ns

// What this block does
// RULE_01 - Direct value outside min/max sets flag
// RULE_02 - Direct-write error rejects whole output array
// RULE_03 - Control bits beyond counter_quantity flag counter
// RULE_04 - Invalid counter rejects whole output array
// RULE_05 - Rate valid only while rate current
// RULE_06 - Rate frozen at last good value
// RULE_07 - Wrap within period clears rate valid
// RULE_08 - Config outside count forces preset, warns
// RULE_09 - Preset warning cleared on clear rising edge
// RULE_10 - Some flags sticky, others follow conditions
// RULE_11 - Arrays take defaults at power-up
// RULE_12 - Inputs, flags, outputs cleared at power-up
// RULE_13 - Overflow and underflow reported in status
// RULE_14 - Faults and config errors reported, indicated
// RULE_15 - Wrap flags cleared on clear rising edge
// RULE_16 - Range compare uses reported rate always
// RULE_17 - Edges found between accepted arrays only
module csf_top
   import csf_pkg::*;
(
   // Clock and reset
   input  wire logic                     mclk,
   input  wire logic                     rstn,
   // Register port
   input  wire logic [AW-1:0]            addr,
   input  wire logic [31:0]              wdata,
   input  wire logic                     wr,
   input  wire logic                     rd,
   output logic      [31:0]              rdata,
   // Counting engine side
   input  wire csf_evt_s [NCTR-1:0]      evt,
   input  wire logic [NCTR-1:0][CW-1:0]  present_count,
   input  wire logic [NCTR-1:0][CW-1:0]  rate_in,
   input  wire logic                     hw_fault,
   output logic      [NCTR-1:0]          preset_load,
   output logic      [NCTR-1:0][CW-1:0]  preset_value,
   output logic      [NCTR-1:0][CW-1:0]  reported_rate,
   output logic      [NCTR-1:0]          run_enable,
   // Status
   output csf_stat_s [NCTR-1:0]          status,
   output logic                          error_ind
);

   // Address decode
   wire [3:0] bank   = addr[7:4];                  // Bank select
   wire [1:0] cix    = addr[3:2];                  // Counter within bank
   wire       wr_ctl = wr && addr == A_OUT_CTRL;
   wire       out_go = wr && addr == A_OUT_COMMIT;  // Output array submitted
   wire       wr_qty = wr && addr == A_CFG_QTY;
   wire       cfg_go = wr && addr == A_CFG_COMMIT;  // Configuration submitted

   // Output array, staged and accepted copies
   logic [31:0] st_ctrl_r;                          // Control bits as written
   logic [31:0] act_ctrl_r;                         // Control bits in effect
   logic [2:0]  st_qty_r;                           // Staged counter_quantity
   logic [2:0]  qty_r;                              // Accepted counter_quantity
   logic        rej_r;                              // Last submit refused
   logic        hwf_r;                              // Registered fault input
   logic        err_r;                              // Indicator drive

   // Per-counter results
   logic [NCTR-1:0]          dw_bad;                // Direct value out of range
   logic [NCTR-1:0]          ic_bad;                // Control bits on absent counter
   logic [NCTR-1:0][3:0]     stk;                   // Sticky flags per counter
   logic [NCTR-1:0]          rv;                    // Rate valid per counter
   logic [NCTR-1:0][CW-1:0]  dir_rd;                // Readback banks
   logic [NCTR-1:0][CW-1:0]  max_rd;
   logic [NCTR-1:0][CW-1:0]  min_rd;
   logic [NCTR-1:0]          idw_r;                 // Registered condition flags
   logic [NCTR-1:0]          ic_r;

   // Whole-array acceptance: a direct-value or invalid-counter error on any counter refuses everything
   wire out_ok     = ~|dw_bad && ~|ic_bad;          // RULE_02 RULE_04
   wire out_accept = out_go && out_ok;
   // Clear requests are rising edges between accepted arrays only
   wire [31:0] rise = out_accept ? (st_ctrl_r & ~act_ctrl_r) : 32'h0000_0000; // RULE_17

   // Control word and quantity registers
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         st_ctrl_r  <= RST_CTRL;                    // RULE_11
         act_ctrl_r <= RST_CTRL;
         st_qty_r   <= RST_QTY;
         qty_r      <= RST_QTY;
      end else begin
         if (wr_ctl) begin
            st_ctrl_r <= wdata;
         end
         // Refused arrays leave prior controls in effect
         if (out_accept) begin
            act_ctrl_r <= st_ctrl_r;                // RULE_17
         end
         if (wr_qty) begin
            st_qty_r <= wdata[2:0];
         end
         if (cfg_go) begin
            qty_r <= st_qty_r;
         end
      end
   end

   // Submit outcome and error summary
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         rej_r <= 1'b0;                             // RULE_12
         hwf_r <= 1'b0;
         err_r <= 1'b0;
      end else begin
         if (out_go) begin
            rej_r <= ~out_ok;                       // RULE_02 RULE_04
         end
         hwf_r <= hw_fault;
         // Indicator shows both faults and configuration errors
         err_r <= hwf_r | (|idw_r) | (|ic_r);       // RULE_14
      end
   end

   // One slice per counter
   genvar n;
   generate
      for (n = 0; n < NCTR; n++) begin : g_ctr
         logic [CW-1:0] st_dir_r;                   // Staged direct value
         logic [CW-1:0] act_dir_r;                  // Accepted direct value
         logic [CW-1:0] st_max_r;                   // Staged configuration
         logic [CW-1:0] st_min_r;
         logic [CW-1:0] st_pre_r;
         logic [CW-1:0] max_r;                      // Accepted configuration
         logic [CW-1:0] min_r;
         logic [CW-1:0] pre_r;
         logic          pload_r;                    // Preset force pulse
         logic [3:0]    stk_r;
         logic          rv_r;
         logic [CW-1:0] rate_r;
         csf_clr_s      clr;
         wire           sel    = cix == 2'(n);
         wire [7:0]     cbits  = st_ctrl_r[n*CTLW +: CTLW];
         wire [7:0]     rbits  = rise[n*CTLW +: CTLW];
         // Signed range checks against the accepted limits
         wire           dir_hi = $signed(st_dir_r) > $signed(max_r);
         wire           dir_lo = $signed(st_dir_r) < $signed(min_r);
         // New limits versus the live count at configuration accept
         wire           pre_hi = $signed(st_min_r) > $signed(present_count[n]);
         wire           pre_lo = $signed(st_max_r) < $signed(present_count[n]);

         assign dw_bad[n] = dir_hi | dir_lo;                        // RULE_01
         assign ic_bad[n] = IC_PRESENT[n] && (|cbits) && (qty_r < 3'(n)); // RULE_03
         assign clr.ovf   = rbits[CB_CLR_OVF];                      // RULE_15
         assign clr.udf   = rbits[CB_CLR_UDF];
         assign clr.idx   = rbits[CB_CLR_IDX];
         assign clr.pw    = rbits[CB_CLR_PW];                       // RULE_09

         // Bank registers of this counter
         always_ff @(posedge mclk) begin
            if (!rstn) begin
               st_dir_r  <= RST_DIRECT;             // RULE_11
               act_dir_r <= RST_DIRECT;
               st_max_r  <= RST_MAX;
               st_min_r  <= RST_MIN;
               st_pre_r  <= RST_PRESET;
               max_r     <= RST_MAX;
               min_r     <= RST_MIN;
               pre_r     <= RST_PRESET;
               pload_r   <= 1'b0;
            end else begin
               if (wr && sel && bank == B_DIRECT) begin
                  st_dir_r <= wdata;
               end
               if (wr && sel && bank == B_MAX) begin
                  st_max_r <= wdata;
               end
               if (wr && sel && bank == B_MIN) begin
                  st_min_r <= wdata;
               end
               if (wr && sel && bank == B_PRESET) begin
                  st_pre_r <= wdata;
               end
               if (out_accept) begin
                  act_dir_r <= st_dir_r;            // RULE_02
               end
               if (cfg_go) begin
                  max_r <= st_max_r;
                  min_r <= st_min_r;
                  pre_r <= st_pre_r;
               end
               // Count outside new limits is forced to the new preset
               pload_r <= cfg_go && (pre_hi || pre_lo); // RULE_08
            end
         end

         // Condition flags follow their causes, no manual clear
         always_ff @(posedge mclk) begin
            if (!rstn) begin
               idw_r[n] <= 1'b0;
               ic_r[n]  <= 1'b0;
            end else begin
               idw_r[n] <= dw_bad[n];               // RULE_10
               ic_r[n]  <= ic_bad[n];
            end
         end

         csf_flag_unit u_flags (
            .mclk     (mclk),
            .rstn     (rstn),
            .evt      (evt[n]),
            .clr      (clr),
            .pw_set   (pload_r),
            .rate_in  (rate_in[n]),
            .sticky_r (stk_r),
            .rv_r     (rv_r),
            .rate_r   (rate_r)
         );

         assign stk[n]           = stk_r;
         assign rv[n]            = rv_r;
         assign preset_load[n]   = pload_r;         // RULE_08
         assign preset_value[n]  = pre_r;
         // Range logic reads this even when rate_valid is low
         assign reported_rate[n] = rate_r;          // RULE_16
         assign run_enable[n]    = act_ctrl_r[n*CTLW + CB_RUN];
         assign dir_rd[n]        = act_dir_r;
         assign max_rd[n]        = max_r;
         assign min_rd[n]        = min_r;
         // Status word; missing flags of a counter read as zero
         assign status[n].ovf = stk_r[0];           // RULE_13
         assign status[n].udf = stk_r[1];           // RULE_13
         assign status[n].idx = stk_r[2] & IDX_PRESENT[n];
         assign status[n].direct_write_invalid = idw_r[n];           // RULE_01
         assign status[n].ic  = ic_r[n] & IC_PRESENT[n];
         assign status[n].rv  = rv_r;               // RULE_05
         assign status[n].pw  = stk_r[3];           // RULE_08
      end
   endgenerate

   assign error_ind = err_r;                        // RULE_14

   // Read multiplexer, unmapped words read zero
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0000_0000;
      case (bank)
         4'h0: begin
            if (cix == 2'h0) begin
               rd_mux = st_ctrl_r;
            end else if (cix == 2'h2) begin
               rd_mux = {29'h0, qty_r};
            end
         end
         4'h1: begin
            if (cix == 2'h0) begin
               rd_mux = {29'h0, rej_r, err_r, hwf_r}; // RULE_14
            end
         end
         B_DIRECT: rd_mux = dir_rd[cix];
         B_MAX:    rd_mux = max_rd[cix];
         B_MIN:    rd_mux = min_rd[cix];
         B_PRESET: rd_mux = preset_value[cix];
         B_STAT:   rd_mux = {25'h0, status[cix]};   // RULE_13
         B_RATE:   rd_mux = reported_rate[cix];
         default:  rd_mux = 32'h0000_0000;
      endcase
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         rdata <= 32'h0000_0000;
      end else begin
         rdata <= rd ? rd_mux : 32'h0000_0000;
      end
   end

   // Checks
   AST_DW_FLAG: assert property (@(posedge mclk) disable iff (!rstn) // RULE_01
      dw_bad[0] |=> status[0].direct_write_invalid)
      else $error("direct write flag missing");
   AST_DW_REJECT: assert property (@(posedge mclk) disable iff (!rstn) // RULE_02
      (out_go && |dw_bad) |=> ($stable(act_ctrl_r) && rej_r))
      else $error("bad direct value array accepted");
   AST_IC_REJECT: assert property (@(posedge mclk) disable iff (!rstn) // RULE_04
      (out_go && |ic_bad) |=> ($stable(g_ctr[3].act_dir_r) && rej_r))
      else $error("invalid counter array accepted");
   AST_IC_FLAG: assert property (@(posedge mclk) disable iff (!rstn) // RULE_03
      (qty_r < 3'h3 && |st_ctrl_r[31:24]) |=> status[3].ic)
      else $error("invalid counter flag missing");
   AST_PRESET_FORCE: assert property (@(posedge mclk) disable iff (!rstn) // RULE_08
      preset_load[3] |=> status[3].pw)
      else $error("preset force without warning");
   AST_EDGE_ONLY: assert property (@(posedge mclk) disable iff (!rstn) // RULE_17
      (out_go && !out_ok) |=> ($stable(act_ctrl_r) && $stable(g_ctr[0].act_dir_r)))
      else $error("edge passed on refused array");
   AST_ERR_IND: assert property (@(posedge mclk) disable iff (!rstn) // RULE_14
      hw_fault |-> ##2 error_ind)
      else $error("fault not indicated");
   AST_RD_ONCE: assert property (@(posedge mclk) disable iff (!rstn)
      !$past(rd) |-> rdata == 32'h0000_0000)
      else $error("read data outside its cycle");
   COV_ACCEPT: cover property (@(posedge mclk) disable iff (!rstn) out_accept);
   COV_REJECT: cover property (@(posedge mclk) disable iff (!rstn) out_go && !out_ok);
   COV_PRESET: cover property (@(posedge mclk) disable iff (!rstn) |preset_load);

endmodule

//--- verification/csf_ctl_model.sv
// Purpose: Bus master model of the controller that owns the output and config arrays
// Assumes: One access per call, strobes launched just after a rising edge
// Notes:   Write data is inverted once released so stale data never looks valid
`timescale 1ns/1ns
module csf_ctl_model
   import csf_pkg::*;
(
   // Clock and read data
   input  wire logic          mclk,
   input  wire logic [31:0]   rdata,
   // Request lines
   output logic      [AW-1:0] addr,
   output logic      [31:0]   wdata,
   output logic               wr,
   output logic               rd
);
   // Idle bus at time zero
   initial begin
      addr  = '0;
      wdata = '0;
      wr    = 1'b0;
      rd    = 1'b0;
   end
   // One-cycle write; clear edges come from two submitted control arrays, 0 then 1
   task automatic bus_wr(input logic [AW-1:0] a, input logic [31:0] v);
      @(posedge mclk);
      addr  <= a;
      wdata <= v;
      wr    <= 1'b1;
      @(posedge mclk);
      wr    <= 1'b0;
      wdata <= ~v;
   endtask
   // One-cycle read; data stands only in the next cycle, taken at its closing edge
   task automatic bus_rd(input logic [AW-1:0] a, output logic [31:0] v);
      @(posedge mclk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      @(posedge mclk);
      v = rdata;
   endtask
endmodule

//--- verification/csf_top_test.sv
// Purpose: Self-checking bench for the counter status and error flag block
// Assumes: Controller model drives the register port, bench drives engine events
// Notes:   Expectations are worked out by hand from the flag behaviour
`timescale 1ns/1ns
module csf_top_test
   import csf_pkg::*;
;
   logic                    mclk = 1'b0;   // 100 MHz
   logic                    rstn = 1'b0;   // Sync, active low
   logic [AW-1:0]           addr;
   logic [31:0]             wdata, rdata, d;
   logic                    wr, rd, err_ind;
   logic                    hw_fault = 1'b0;
   csf_evt_s [NCTR-1:0]     evt = '0;      // Engine event pulses
   logic [NCTR-1:0][CW-1:0] cnt = '0;      // Live counts
   logic [NCTR-1:0][CW-1:0] rate = '0;     // Raw rates
   logic [NCTR-1:0][CW-1:0] pval, rrate;
   logic [NCTR-1:0]         pload, run;
   csf_stat_s [NCTR-1:0]    status;
   logic                    pl_seen = 1'b0; // Catches the one-cycle preset pulse
   int                      n_mismatch = 0;
   int                      compares = 0;
   int                      k;

   always #5 mclk = ~mclk;
   always @(posedge mclk) if (pload[3]) pl_seen <= 1'b1;

   csf_ctl_model u_csf_ctl_model (.mclk(mclk), .rdata(rdata), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd));
   csf_top u_csf_top (.mclk(mclk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .evt(evt), .present_count(cnt), .rate_in(rate), .hw_fault(hw_fault),
      .preset_load(pload), .preset_value(pval), .reported_rate(rrate), .run_enable(run),
      .status(status), .error_ind(err_ind));

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         n_mismatch++;
         $display("unexpected %s: expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic rchk(input string nm, input logic [AW-1:0] a, input logic [31:0] e);
      u_csf_ctl_model.bus_rd(a, d);
      chk(nm, e, d);
   endtask
   // Stage a word, submit, let the flags settle
   task automatic sub(input logic [AW-1:0] a, input logic [31:0] v, input logic [AW-1:0] c);
      u_csf_ctl_model.bus_wr(a, v);
      u_csf_ctl_model.bus_wr(c, 32'h0000_0000);
      repeat (3) @(posedge mclk);
   endtask
   task automatic pulse(input int n, input logic [3:0] e);
      @(posedge mclk);
      evt[n] <= csf_evt_s'(e);
      @(posedge mclk);
      evt[n] <= '0;
      repeat (2) @(posedge mclk);
   endtask
   task automatic report_and_stop;
      if (n_mismatch == 0 && compares > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // Hang guard
   initial begin
      repeat (20000) @(posedge mclk);
      n_mismatch++;
      report_and_stop();
   end

   initial begin
      repeat (16) @(posedge mclk);
      rstn <= 1'b1;
      for (k = 0; k < NCTR; k++) begin
         rchk("status", 8'h60 + 8'(4 * k), 32'h0);
         rchk("rate", 8'h70 + 8'(4 * k), 32'h0);
      end
      chk("outputs", 32'h0, {23'h0, pload, run, err_ind});
      // Wrap flags: set, cleared on an edge, kept under a steady level
      pulse(0, 4'h8);
      rchk("ovf", 8'h60, 32'h1);
      pulse(1, 4'h4);
      rchk("udf", 8'h64, 32'h2);
      sub(A_OUT_CTRL, 32'h0000_0201, A_OUT_COMMIT);
      rchk("ovf clr", 8'h60, 32'h0);
      rchk("udf clr", 8'h64, 32'h0);
      pulse(0, 4'h8);
      sub(A_OUT_CTRL, 32'h0000_0201, A_OUT_COMMIT);
      rchk("ovf held", 8'h60, 32'h1);
      sub(A_OUT_CTRL, 32'h0000_0000, A_OUT_COMMIT);
      sub(A_OUT_CTRL, 32'h0000_0001, A_OUT_COMMIT);
      rchk("ovf clr2", 8'h60, 32'h0);
      // Rate valid and frozen rate on counter 2
      rate[2] <= 32'h0000_1234;
      pulse(2, 4'h1);
      rchk("rv", 8'h68, 32'h20);
      pulse(2, 4'h8);
      rate[2] <= 32'h0000_5678;
      pulse(2, 4'h1);
      rchk("rv wrap", 8'h68, 32'h1);
      rchk("rate held", 8'h78, 32'h0000_1234);
      pulse(2, 4'h1);
      chk("rate new", 32'h0000_5678, rrate[2]);
      // Control bits beyond the counter quantity
      for (k = 1; k < NCTR; k++) begin
         sub(A_CFG_QTY, 32'(k - 1), A_CFG_COMMIT);
         sub(A_OUT_CTRL, 32'h0000_0010 << (8 * k), A_OUT_COMMIT);
         u_csf_ctl_model.bus_rd(8'h60 + 8'(4 * k), d);
         chk("ic", 32'h1, 32'(d[4]));
         chk("run refused", 32'h0, 32'(run[k]));
         chk("error ind", 32'h1, 32'(err_ind));
         u_csf_ctl_model.bus_rd(A_ERR, d);
         chk("err rej", 32'h1, 32'(d[2]));
         sub(A_OUT_CTRL, 32'h0000_0000, A_OUT_COMMIT);
         u_csf_ctl_model.bus_rd(8'h60 + 8'(4 * k), d);
         chk("ic gone", 32'h0, 32'(d[4]));
      end
      sub(A_CFG_QTY, 32'h0000_0003, A_CFG_COMMIT);
      // Direct value above the maximum, then exactly at it
      sub(8'h30, 32'h0000_0064, A_CFG_COMMIT);
      u_csf_ctl_model.bus_wr(8'h20, 32'h0000_0065);
      sub(A_OUT_CTRL, 32'h0000_0010, A_OUT_COMMIT);
      rchk("idw", 8'h60, 32'h8);
      chk("run refused", 32'h0, 32'(run[0]));
      sub(8'h20, 32'h0000_0064, A_OUT_COMMIT);
      rchk("idw gone", 8'h60, 32'h0);
      chk("run taken", 32'h1, 32'(run[0]));
      // Minimum above the live count forces the preset
      cnt[3] <= 32'h0000_0032;
      u_csf_ctl_model.bus_wr(8'h2C, 32'h0000_0064);
      u_csf_ctl_model.bus_wr(8'h5C, 32'h0000_0007);
      sub(8'h4C, 32'h0000_0064, A_CFG_COMMIT);
      for (k = 0; k < 8 && !pl_seen; k++) @(posedge mclk);
      chk("preset load", 32'h1, 32'(pl_seen));
      chk("preset value", 32'h0000_0007, pval[3]);
      rchk("pw", 8'h6C, 32'h40);
      sub(A_OUT_CTRL, 32'h0800_0000, A_OUT_COMMIT);
      rchk("pw clr", 8'h6C, 32'h0);
      sub(A_CFG_COMMIT, 32'h0000_0000, A_OUT_COMMIT);
      rchk("pw level", 8'h6C, 32'h40);
      // Hardware fault reaches the indicator and the error word
      hw_fault <= 1'b1;
      repeat (3) @(posedge mclk);
      chk("hw ind", 32'h1, 32'(err_ind));
      u_csf_ctl_model.bus_rd(A_ERR, d);
      chk("err hw", 32'h1, 32'(d[0]));
      hw_fault <= 1'b0;
      report_and_stop();
   end
endmodule
